// *** rtl/sec_eeprom_ctrl.sv ***
// Serial EEPROM controller: station address load and host commands
//
// Behaviour
// - After any reset read location zero; memory valid only if it holds A5h.
// - On valid signature load six following bytes into station address, byte 0 first.
// - Set address-loaded once all six bytes are stored.
// - Bad signature ends load; address untouched, loaded bit left clear from load start.
// - Reload command repeats check and load; loaded bit shows success.
// - Command runs only when busy is set; busy clears itself when done.
// - Read byte sits in the data register when busy clears.
// - No memory response within 30 ms abandons operation and sets timeout.
// - Interface disabled: pins become general outputs or internal monitors.
// - Memory is 128 locations of 8 bits; read, write, erase supported.
// - Frames last 10 serial clocks for short commands, 18 for data ones.
// - Write-all stores the data register byte into every location.
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.svh"

module sec_eeprom_ctrl #(
  parameter int TIMEOUT_CYCLES = `SEC_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic cmdWrite,
  input wire sec_pkg::sec_cmd_t cmdIn,
  input wire logic dataWrite,
  input wire logic [7:0] dataIn,
  input wire logic interfaceEnable,
  input wire logic monitorSelect,
  input wire logic [1:0] gpioValue,
  input wire logic [1:0] monitorSignals,
  input wire logic memDataIn,
  output logic operationBusyBit,
  output logic responseTimeoutFlag,
  output logic addressLoaded,
  output logic [7:0] eepromDataRegister,
  output logic [31:0] stationAddressLow,
  output logic [15:0] stationAddressHigh,
  output sec_pkg::sec_pins_t memPins
);

  localparam int HW = $clog2(`SEC_HALF_CYC + 1);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  sec_pkg::sec_state_t state, next_state;
  sec_pkg::sec_cmd_t curCmd, next_curCmd;
  sec_pkg::sec_pins_t ctlPins, next_ctlPins, next_memPins;
  logic busy, next_busy, timeout, next_timeout, loaded, next_loaded;
  logic loading, next_loading;
  logic [2:0] loadIndex, next_loadIndex;
  logic [7:0] dataReg, next_dataReg, rxShift, next_rxShift;
  logic [47:0] stationAddress, next_stationAddress;
  logic [17:0] shifter, next_shifter;
  logic [4:0] bitCount, next_bitCount, frameLen, next_frameLen;
  logic [HW-1:0] tickCount, next_tickCount;
  logic [TW-1:0] waitCount, next_waitCount;
  logic dinMeta, dinSync, tick;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // frame layout
  // Start bit, opcode, 7-bit location, then data, left aligned
  function automatic logic [17:0] frameFor(logic [2:0] code, logic [6:0] loc,
                                           logic [7:0] data);
    logic [17:0] f;
    f = {`SEC_START_BIT, `SEC_OP_READ, loc, `SEC_NO_DATA};
    unique case (code)
      `SEC_CMD_WRITE: f = {`SEC_START_BIT, `SEC_OP_WRITE, loc, data};
      `SEC_CMD_ERASE: f = {`SEC_START_BIT, `SEC_OP_ERASE, loc, `SEC_NO_DATA};
      `SEC_CMD_ERASE_WRITE_ENABLE_CMD: f = {`SEC_START_BIT, `SEC_OP_EXT, `SEC_EXT_ERASE_WRITE_ENABLE_CMD, `SEC_NO_DATA};
      `SEC_CMD_ERASE_WRITE_DISABLE_CMD: f = {`SEC_START_BIT, `SEC_OP_EXT, `SEC_EXT_ERASE_WRITE_DISABLE_CMD, `SEC_NO_DATA};
      `SEC_CMD_ERASE_ALL_CMD: f = {`SEC_START_BIT, `SEC_OP_EXT, `SEC_EXT_ERASE_ALL_CMD, `SEC_NO_DATA};
      `SEC_CMD_WRITE_ALL_LOCATIONS_CMD: f = {`SEC_START_BIT, `SEC_OP_EXT, `SEC_EXT_WRITE_ALL_LOCATIONS_CMD, data};
      default: f = {`SEC_START_BIT, `SEC_OP_READ, loc, `SEC_NO_DATA};
    endcase
    return f;
  endfunction : frameFor

  // Commands that program the array and must be polled for ready
  function automatic logic needsPoll(logic [2:0] code);
    return code == `SEC_CMD_WRITE || code == `SEC_CMD_WRITE_ALL_LOCATIONS_CMD ||
           code == `SEC_CMD_ERASE || code == `SEC_CMD_ERASE_ALL_CMD;
  endfunction : needsPoll

  function automatic logic [4:0] lenFor(logic [2:0] code);
    return (code == `SEC_CMD_READ || code == `SEC_CMD_WRITE || code == `SEC_CMD_WRITE_ALL_LOCATIONS_CMD)
           ? `SEC_LONG_LEN : `SEC_SHORT_LEN;
  endfunction : lenFor

  // Data pin comes from another domain: two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dinMeta <= 1'b0;
      dinSync <= 1'b0;
    end else begin
      dinMeta <= memDataIn;
      dinSync <= dinMeta;
    end
  end

  // Controller next state
  always_comb begin
    next_state = state;
    next_curCmd = curCmd;
    next_ctlPins = ctlPins;
    next_busy = busy;
    next_timeout = timeout;
    next_loaded = loaded;
    next_loading = loading;
    next_loadIndex = loadIndex;
    next_dataReg = dataReg;
    next_rxShift = rxShift;
    next_stationAddress = stationAddress;
    next_shifter = shifter;
    next_bitCount = bitCount;
    next_frameLen = frameLen;
    next_waitCount = waitCount;
    tick = (tickCount == HW'(`SEC_HALF_CYC - 1));
    next_tickCount = tick ? '0 : tickCount + HW'(1);
    if (dataWrite && !busy) begin
      next_dataReg = dataIn;
    end
    if (softReset) begin
      next_state = sec_pkg::SecIdle;
      next_ctlPins = '0;
      next_loading = 1'b1;
      next_loadIndex = '0;
      next_loaded = 1'b0;
      next_busy = 1'b1;
    end else if (interfaceEnable) begin
      // Disabled interface freezes the sequencer mid-step
      unique case (state)
        sec_pkg::SecIdle: begin
          // launch only on host busy write
          if (!loading && !busy && cmdWrite && cmdIn.start) begin
            next_curCmd = cmdIn;
            next_busy = 1'b1;
            next_timeout = 1'b0;
            if (cmdIn.code == `SEC_CMD_RELOAD) begin
              next_loading = 1'b1;
              next_loadIndex = '0;
              next_loaded = 1'b0;
            end
          end
          if (loading || (!busy && cmdWrite && cmdIn.start &&
                          cmdIn.code != `SEC_CMD_RELOAD)) begin
            if (loading) begin
              next_shifter = frameFor(`SEC_CMD_READ, 7'(loadIndex), `SEC_NO_DATA);
              next_frameLen = `SEC_LONG_LEN;
            end else begin
              next_shifter = frameFor(cmdIn.code, cmdIn.location, dataReg);
              next_frameLen = lenFor(cmdIn.code);
            end
            next_ctlPins = '{select: 1'b1, clock: 1'b0,
                             dataOut: next_shifter[17], dataOe: 1'b1};
            next_bitCount = '0;
            next_tickCount = '0;
            next_state = sec_pkg::SecFrame;
          end
        end
        sec_pkg::SecFrame: begin
          if (tick && !ctlPins.clock) begin
            next_ctlPins.clock = 1'b1;
            next_bitCount = bitCount + 5'h01;
          end else if (tick) begin
            // Sample late in the high phase so read data has settled
            next_rxShift = {rxShift[6:0], dinSync};
            next_ctlPins.clock = 1'b0;
            // stop after the fixed clock count
            if (bitCount == frameLen) begin
              next_ctlPins = '0;
              next_state = sec_pkg::SecGap;
            end else begin
              next_shifter = {shifter[16:0], 1'b0};
              next_ctlPins.dataOut = shifter[16];
              // release data line
              // Location is out after the short-frame count; the memory owns the line then
              if (bitCount == `SEC_SHORT_LEN && (loading || curCmd.code == `SEC_CMD_READ)) begin
                next_ctlPins.dataOe = 1'b0;
              end
            end
          end
        end
        sec_pkg::SecGap: begin
          if (tick) begin
            next_state = sec_pkg::SecIdle;
            if (!loading && needsPoll(curCmd.code)) begin
              // Reselect and wait for the memory to signal ready
              next_ctlPins.select = 1'b1;
              next_waitCount = '0;
              next_state = sec_pkg::SecPoll;
            end else if (!loading) begin
              // read byte ready with busy clear
              if (curCmd.code == `SEC_CMD_READ) begin
                next_dataReg = rxShift;
              end
              next_busy = 1'b0;
            end else if (loadIndex == 3'h0) begin
              if (rxShift == `SEC_SIGNATURE) begin
                next_loadIndex = 3'h1;
              end else begin
                next_loading = 1'b0;
                next_busy = 1'b0;
              end
            end else begin
              next_stationAddress[6'({loadIndex - 3'h1, 3'h0}) +: 8] = rxShift;
              next_loadIndex = loadIndex + 3'h1;
              if (loadIndex == `SEC_ADDR_BYTES) begin
                next_loaded = 1'b1;
                next_loading = 1'b0;
                next_busy = 1'b0;
              end
            end
          end
        end
        sec_pkg::SecPoll: begin
          next_waitCount = waitCount + TW'(1);
          // Early samples still show the released line from before reselect
          if (dinSync && waitCount >= TW'(`SEC_POLL_SETTLE)) begin
            next_ctlPins = '0;
            next_busy = 1'b0;
            next_state = sec_pkg::SecIdle;
          end else if (waitCount == TW'(TIMEOUT_CYCLES - 1)) begin
            next_timeout = 1'b1;
            next_ctlPins = '0;
            next_busy = 1'b0;
            next_state = sec_pkg::SecIdle;
          end
        end
      endcase
    end
  end

  // Controller registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= sec_pkg::SecIdle;
      curCmd <= '0;
      ctlPins <= '0;
      busy <= 1'b1;
      timeout <= 1'b0;
      loaded <= 1'b0;
      loading <= 1'b1;
      loadIndex <= '0;
      dataReg <= '0;
      rxShift <= '0;
      stationAddress <= '0;
      shifter <= '0;
      bitCount <= '0;
      frameLen <= '0;
      tickCount <= '0;
      waitCount <= '0;
    end else begin
      state <= next_state;
      curCmd <= next_curCmd;
      ctlPins <= next_ctlPins;
      busy <= next_busy;
      timeout <= next_timeout;
      loaded <= next_loaded;
      loading <= next_loading;
      loadIndex <= next_loadIndex;
      dataReg <= next_dataReg;
      rxShift <= next_rxShift;
      stationAddress <= next_stationAddress;
      shifter <= next_shifter;
      bitCount <= next_bitCount;
      frameLen <= next_frameLen;
      tickCount <= next_tickCount;
      waitCount <= next_waitCount;
    end
  end

  // pin sharing when interface is disabled
  always_comb begin
    next_memPins = ctlPins;
    if (!interfaceEnable) begin
      next_memPins.select = 1'b0;
      next_memPins.clock = monitorSelect ? monitorSignals[1] : gpioValue[1];
      next_memPins.dataOut = monitorSelect ? monitorSignals[0] : gpioValue[0];
      next_memPins.dataOe = 1'b1;
    end
  end

  // Pin register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      memPins <= '0;
    end else begin
      memPins <= next_memPins;
    end
  end

  assign operationBusyBit = busy;
  assign responseTimeoutFlag = timeout;
  assign addressLoaded = loaded;
  assign eepromDataRegister = dataReg;
  assign stationAddressLow = stationAddress[31:0];
  assign stationAddressHigh = stationAddress[47:32];

  frame_len_a: assert property (
    state == sec_pkg::SecGap && $past(state) == sec_pkg::SecFrame |->
      bitCount == frameLen && (frameLen == `SEC_SHORT_LEN || frameLen == `SEC_LONG_LEN))
    else $error("frame clock count wrong");

  gap_deselect_a: assert property (
    state == sec_pkg::SecGap |-> !ctlPins.select && !ctlPins.clock)
    else $error("memory selected in gap");

  start_bit_a: assert property (
    state == sec_pkg::SecFrame && $past(state) == sec_pkg::SecIdle |->
      ctlPins.dataOut == `SEC_START_BIT && ctlPins.select)
    else $error("frame does not open with start bit");

  busy_cause_a: assert property (
    $rose(busy) |-> $past(softReset || (cmdWrite && cmdIn.start)))
    else $error("busy set without cause");

  idle_hold_a: assert property (
    state == sec_pkg::SecIdle && !busy && !softReset && !(cmdWrite && cmdIn.start) |=>
      state == sec_pkg::SecIdle)
    else $error("operation started without busy");

  read_data_a: assert property (
    $fell(busy) && $past(curCmd.code) == `SEC_CMD_READ && !$past(loading) &&
      $past(state) == sec_pkg::SecGap |-> dataReg == $past(rxShift))
    else $error("read byte missing at busy clear");

  loaded_set_a: assert property (
    $rose(loaded) |-> $past(loading && loadIndex == `SEC_ADDR_BYTES))
    else $error("loaded bit set early");

  addr_guard_a: assert property (
    stationAddress != $past(stationAddress) |-> $past(loading && loadIndex != 3'h0))
    else $error("address changed outside load");

  timeout_set_a: assert property (
    $rose(timeout) |-> $past(state) == sec_pkg::SecPoll &&
      $past(waitCount) == TW'(TIMEOUT_CYCLES - 1) && !busy)
    else $error("timeout raised at wrong time");

  gpio_pins_a: assert property (
    !interfaceEnable |=> memPins.dataOe && !memPins.select &&
      memPins.dataOut == ($past(monitorSelect) ? $past(monitorSignals[0]) : $past(gpioValue[0])))
    else $error("pins not handed to general use");

endmodule : sec_eeprom_ctrl
`default_nettype wire

// *** rtl/sec_regs.svh ***
// Constants for the serial EEPROM controller: codes, frame layout, timing
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

`define SEC_SIGNATURE 8'hA5
`define SEC_ADDR_BYTES 3'h6
`define SEC_SHORT_LEN 5'h0A
`define SEC_LONG_LEN 5'h12
`define SEC_START_BIT 1'h1
`define SEC_NO_DATA 8'h00

// Host command codes in the command code field
`define SEC_CMD_READ 3'h0
`define SEC_CMD_ERASE_WRITE_DISABLE_CMD 3'h1
`define SEC_CMD_ERASE_WRITE_ENABLE_CMD 3'h2
`define SEC_CMD_WRITE 3'h3
`define SEC_CMD_WRITE_ALL_LOCATIONS_CMD 3'h4
`define SEC_CMD_ERASE 3'h5
`define SEC_CMD_ERASE_ALL_CMD 3'h6
`define SEC_CMD_RELOAD 3'h7

// Serial opcodes and extended-command address patterns
`define SEC_OP_EXT 2'h0
`define SEC_OP_WRITE 2'h1
`define SEC_OP_READ 2'h2
`define SEC_OP_ERASE 2'h3
`define SEC_EXT_ERASE_WRITE_DISABLE_CMD 7'h00
`define SEC_EXT_WRITE_ALL_LOCATIONS_CMD 7'h20
`define SEC_EXT_ERASE_ALL_CMD 7'h40
`define SEC_EXT_ERASE_WRITE_ENABLE_CMD 7'h60

// Timing: system clock 40 MHz, serial half period, response limit
`define SEC_CLK_PERIOD_NS 25
`define SEC_HALF_NS 500
`define SEC_HALF_CYC ((`SEC_HALF_NS + `SEC_CLK_PERIOD_NS - 1) / `SEC_CLK_PERIOD_NS)
`define SEC_TIMEOUT_NS 30000000
`define SEC_TIMEOUT_CYC (`SEC_TIMEOUT_NS / `SEC_CLK_PERIOD_NS)
// Poll cycles before the ready level is trusted: pin register plus two sync flops
`define SEC_POLL_SETTLE 4

`endif

// *** rtl/sec_pkg.sv ***
// Types shared by the serial EEPROM controller
package sec_pkg;

  // Host write to the EEPROM command register
  typedef struct packed {
    logic [2:0] code;
    logic [6:0] location;
    logic start;
  } sec_cmd_t;

  // Serial memory pins
  typedef struct packed {
    logic select;
    logic clock;
    logic dataOut;
    logic dataOe;
  } sec_pins_t;

  typedef enum logic [1:0] {
    SecIdle,
    SecFrame,
    SecGap,
    SecPoll
  } sec_state_t;

endpackage : sec_pkg

// *** testbench/sec_mem_model.sv ***
// Behavioural model of the 128 x 8 serial memory on the far side
`timescale 1ns/1ps
`default_nettype none

module sec_mem_model (
  input wire logic select,
  input wire logic clock,
  input wire logic dataIn,
  input wire logic stall,
  output logic dataOut
);
  logic [7:0] mem [0:127];
  logic [8:0] cmd = '0;
  logic [7:0] wd = '0;
  int k = 0;
  logic wen = 1'h0;
  logic pend = 1'h0;
  logic drv = 1'h0;
  logic dv = 1'h0;
  logic junk = 1'h0;

  // Released line toggles so no stale level is read by luck
  always #35 junk = ~junk;

  always @(posedge clock) begin
    if (select && k == 0) begin
      k = dataIn ? 1 : 0;
    end else if (select) begin
      k = k + 1;
      if (k <= 10) cmd = {cmd[7:0], dataIn};
      else if (k <= 18) wd = {wd[6:0], dataIn};
      // Dummy zero, then the byte MSB first
      if (cmd[8:7] == 2'h2 && k == 10) begin
        drv = 1'h1;
        dv = 1'h0;
      end
      if (drv && k >= 11 && k <= 18) dv = mem[cmd[6:0]][18 - k];
    end
  end

  // program ops land at deselect, only when enabled
  always @(negedge select) begin
    if (k == 0) begin
      pend = 1'h0;
    end else if (cmd[8:7] == 2'h0) begin
      case (cmd[6:5])
        2'h3: wen = 1'h1;
        2'h0: wen = 1'h0;
        2'h2: if (wen) for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
        default: if (wen && k == 18) for (int i = 0; i < 128; i++) mem[i] = wd;
      endcase
      pend = cmd[6:5] inside {2'h1, 2'h2};
    end else if (cmd[8:7] == 2'h1) begin
      if (wen && k == 18) mem[cmd[6:0]] = wd;
      pend = 1'h1;
    end else if (cmd[8:7] == 2'h3) begin
      if (wen) mem[cmd[6:0]] = 8'hFF;
      pend = 1'h1;
    end
    k = 0;
    drv = 1'h0;
  end

  // Ready shown while polled; stall holds it busy for ever
  assign dataOut = (select && k == 0 && pend) ? !stall : (drv ? dv : junk);
endmodule : sec_mem_model

`default_nettype wire

// *** testbench/test_sec_eeprom_ctrl.sv ***
// Self-checking bench for the serial EEPROM controller
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.svh"

module test_sec_eeprom_ctrl;
  localparam int TO_CYC = 200;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic softReset = 1'h0;
  logic cmdWrite = 1'h0;
  sec_pkg::sec_cmd_t cmdIn = '0;
  logic dataWrite = 1'h0;
  logic [7:0] dataIn = 8'h00;
  logic interfaceEnable = 1'h1;
  logic monitorSelect = 1'h0;
  logic [1:0] gpioValue = 2'h0;
  logic [1:0] monitorSignals = 2'h0;
  logic stall = 1'h0;
  logic memQ;
  logic memDataIn;
  logic operationBusyBit;
  logic responseTimeoutFlag;
  logic addressLoaded;
  logic [7:0] eepromDataRegister;
  logic [31:0] stationAddressLow;
  logic [15:0] stationAddressHigh;
  sec_pkg::sec_pins_t memPins;
  int failCount = 0;
  int nCompared = 0;
  int clkCount = 0;
  int selCount = 0;

  sec_eeprom_ctrl #(.TIMEOUT_CYCLES(TO_CYC)) dut_u (
    .clock(clock), .rst_n(rst_n), .softReset(softReset), .cmdWrite(cmdWrite),
    .cmdIn(cmdIn), .dataWrite(dataWrite), .dataIn(dataIn),
    .interfaceEnable(interfaceEnable), .monitorSelect(monitorSelect),
    .gpioValue(gpioValue), .monitorSignals(monitorSignals), .memDataIn(memDataIn),
    .operationBusyBit(operationBusyBit), .responseTimeoutFlag(responseTimeoutFlag),
    .addressLoaded(addressLoaded), .eepromDataRegister(eepromDataRegister),
    .stationAddressLow(stationAddressLow), .stationAddressHigh(stationAddressHigh),
    .memPins(memPins)
  );

  sec_mem_model mem_u (
    .select(memPins.select), .clock(memPins.clock), .dataIn(memPins.dataOut),
    .stall(stall), .dataOut(memQ)
  );

  // Shared data pin: controller wins while it drives
  assign memDataIn = memPins.dataOe ? memPins.dataOut : memQ;

  initial begin
    forever #12.5 clock = ~clock;
  end

  // Serial clocks and selections per command
  always @(posedge memPins.clock) if (memPins.select) clkCount++;
  always @(posedge memPins.select) selCount++;

  task automatic chkVal(input logic [47:0] got, input logic [47:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chkVal

  task automatic giveVerdict;
    $display("Compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : giveVerdict

  // Bounded wait for busy to drop
  task automatic waitIdle;
    int n;
    n = 0;
    while (operationBusyBit !== 1'h0) begin
      @(posedge clock);
      n++;
      if (n > 8000) begin
        failCount++;
        $display("Error at %0t: busy never cleared", $time);
        giveVerdict();
      end
    end
  endtask : waitIdle

  task automatic setData(input logic [7:0] b);
    @(posedge clock);
    dataWrite <= 1'h1;
    dataIn <= b;
    @(posedge clock);
    dataWrite <= 1'h0;
  endtask : setData

  // Launch one command, check busy, clocks and selections
  task automatic issue(input logic [2:0] code, input logic [6:0] loc, input int clks,
                       input int sels);
    @(posedge clock);
    clkCount = 0;
    selCount = 0;
    cmdWrite <= 1'h1;
    cmdIn <= {code, loc, 1'h1};
    @(posedge clock);
    cmdWrite <= 1'h0;
    cmdIn <= '0;
    @(posedge clock);
    #1;
    chkVal(operationBusyBit, 1'h1); // busy while running
    waitIdle();
    chkVal(clkCount, clks); // serial clock count
    chkVal(selCount, sels); // one select per frame and per ready poll
  endtask : issue

  initial begin
    for (int i = 0; i < 128; i++) mem_u.mem[i] = 8'(8'h11 * i);
    mem_u.mem[0] = 8'hA5;
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    // no command before load is over
    waitIdle();
    // Reset-time load with signature present
    chkVal(addressLoaded, 1'h1); // loaded flag
    chkVal({stationAddressHigh, stationAddressLow}, 48'h665544332211); // byte order
    issue(`SEC_CMD_READ, 7'h7F, 18, 1); // top location
    chkVal(eepromDataRegister, 8'(8'h11 * 127)); // read result
    // Enable, write, read back, erase, write all
    issue(`SEC_CMD_ERASE_WRITE_ENABLE_CMD, 7'h00, 10, 1); // enable first
    setData(8'hC3);
    issue(`SEC_CMD_WRITE, 7'h05, 18, 2); // data then command
    chkVal(mem_u.mem[5], 8'hC3); // frame layout
    issue(`SEC_CMD_READ, 7'h05, 18, 1); // location field
    chkVal(eepromDataRegister, 8'hC3); // read back
    issue(`SEC_CMD_ERASE, 7'h05, 10, 2); // single erase
    chkVal(mem_u.mem[5], 8'hFF); // erased
    setData(8'h3C);
    issue(`SEC_CMD_WRITE_ALL_LOCATIONS_CMD, 7'h00, 18, 2); // write all
    chkVal({mem_u.mem[0], mem_u.mem[127]}, 16'h3C3C); // first and last location
    // Reload without signature keeps the address
    issue(`SEC_CMD_RELOAD, 7'h00, 18, 1); // abandon after one frame
    chkVal(addressLoaded, 1'h0); // failure shown
    chkVal({stationAddressHigh, stationAddressLow}, 48'h665544332211); // untouched
    issue(`SEC_CMD_ERASE_ALL_CMD, 7'h00, 10, 2); // erase all
    chkVal(mem_u.mem[64], 8'hFF); // bulk erase
    issue(`SEC_CMD_ERASE_WRITE_DISABLE_CMD, 7'h00, 10, 1); // short frame
    mem_u.mem[0] = 8'hA5;
    mem_u.mem[1] = 8'h5A;
    issue(`SEC_CMD_RELOAD, 7'h00, 126, 7); // seven frames
    chkVal(addressLoaded, 1'h1); // success shown
    chkVal({stationAddressHigh, stationAddressLow}, 48'hFFFFFFFFFF5A); // new address
    // Soft reset repeats the load
    mem_u.mem[1] = 8'h77;
    @(posedge clock);
    softReset <= 1'h1;
    @(posedge clock);
    softReset <= 1'h0;
    repeat (2) @(posedge clock);
    waitIdle();
    chkVal({stationAddressHigh, stationAddressLow}, 48'hFFFFFFFFFF77); // soft reset load
    chkVal(addressLoaded, 1'h1); // loaded again
    // Silent memory: write times out, next launch clears flag
    @(posedge clock);
    stall <= 1'h1;
    issue(`SEC_CMD_ERASE_WRITE_ENABLE_CMD, 7'h00, 10, 1); // enable
    issue(`SEC_CMD_WRITE, 7'h02, 18, 2); // no ready answer
    chkVal(responseTimeoutFlag, 1'h1); // timeout flag
    @(posedge clock);
    stall <= 1'h0;
    issue(`SEC_CMD_ERASE_WRITE_ENABLE_CMD, 7'h00, 10, 1); // flag cleared on launch
    chkVal(responseTimeoutFlag, 1'h0); // cleared
    // Pins handed to general outputs, then monitors
    @(posedge clock);
    interfaceEnable <= 1'h0;
    gpioValue <= 2'h2;
    repeat (3) @(posedge clock);
    #1;
    chkVal({memPins.select, memPins.clock, memPins.dataOut, memPins.dataOe}, 4'h5); // gpio
    monitorSelect <= 1'h1;
    monitorSignals <= 2'h1;
    repeat (3) @(posedge clock);
    #1;
    chkVal({memPins.select, memPins.clock, memPins.dataOut, memPins.dataOe}, 4'h3); // monitors
    giveVerdict();
  end
endmodule : test_sec_eeprom_ctrl

`default_nettype wire
